// file: design/eia_enhancement_and_indirect_access.v
`timescale 1ns/1ps
`default_nettype none
`include "eia_defs.vh"

module eia_enhancement_and_indirect_access #(
    parameter integer IND_DEPTH = 256,
    parameter integer IND_AW    = 8,
    parameter integer DEB_CYC   = `EIA_DEB_CYC
) (
    input  wire        ref_clk_i,
    input  wire        rst_b_i,
    input  wire [7:0]  reg_addr_i,
    input  wire [7:0]  reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output reg  [7:0]  reg_rdata_o,
    input  wire        ring_burst_end_i,
    input  wire [7:0]  programmed_current_limit_i,
    input  wire        battery_switch_req_i,
    input  wire        loop_v_closed_i,
    input  wire        loop_i_above_hi_i,
    input  wire        loop_i_above_lo_i,
    input  wire        loop_i_closed_i,
    output reg  [7:0]  current_limit_o,
    output reg         tone_gen_one_tick_o,
    output reg         fsk_regs_sel_o,
    output reg         fine_cadence_o,
    output reg         converter_multi_thr_o,
    output reg         impedance_ref_disable_o,
    output reg         battery_switch_o,
    output reg         loop_closed_o,
    output reg         converter_squelch_o,
    output reg  [15:0] tone_gen_one_freq_o,
    output reg         indirect_done_irq_o,
    output reg         indirect_pending_flag_o
);
    // Transfer state, one-hot.
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_WR   = 3'b010;
    localparam [2:0] ST_RD   = 3'b100;

    reg [7:0]  enhancement_enable;
    reg [3:0]  peak_monitor_cal_value;
    reg [15:0] indirect_data_reg;
    reg [7:0]  indirect_address_reg;
    reg        relay_mode_bit;
    reg        external_battery_select;
    reg        data_written;
    reg [2:0]  state;
    reg [15:0] ind_mem [0:IND_DEPTH-1];
    reg        ring_boost;
    reg [31:0] deb_count;
    reg        bat_sync_a;
    reg        bat_sync_b;
    reg        hyst_state;
    reg [7:0]  next_rdata;

    wire upd_tick;
    wire tg_slow_tick;
    wire tg_fast_tick;
    wire fsk_active = enhancement_enable[`EIA_ENH_FSK] & relay_mode_bit;
    wire fsk_change = fsk_active ^ fsk_regs_sel_o;
    wire [IND_AW-1:0] ind_idx = indirect_address_reg[IND_AW-1:0];

    eia_tick_div #(.PERIOD(`EIA_UPD_CYC)) u_upd_div (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .restart_i (1'b0),
        .tick_o    (upd_tick)
    );

    eia_tick_div #(.PERIOD(`EIA_TG_SLOW_CYC)) u_tg_slow (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .restart_i (fsk_change),
        .tick_o    (tg_slow_tick)
    );

    eia_tick_div #(.PERIOD(`EIA_TG_FAST_CYC)) u_tg_fast (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .restart_i (fsk_change),
        .tick_o    (tg_fast_tick)
    );

    // Register writes and the indirect transfer engine share one process.
    // A new address write while a transfer waits replaces it; software should not do that.
    always @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            enhancement_enable      <= `EIA_RST_ENH;
            peak_monitor_cal_value  <= `EIA_RST_PKCAL;
            indirect_data_reg       <= 16'h0000;
            indirect_address_reg    <= 8'h00;
            relay_mode_bit          <= 1'b0;
            external_battery_select <= 1'b0;
            data_written            <= 1'b0;
            state                   <= ST_IDLE;
            indirect_pending_flag_o <= 1'b0;
            indirect_done_irq_o     <= 1'b0;
        end else begin
            if (reg_wr_i) begin
                case (reg_addr_i)
                    `EIA_OFF_PKCAL: begin
                        peak_monitor_cal_value <= reg_wdata_i[3:0];
                    end
                    `EIA_OFF_ENH: begin
                        enhancement_enable <= reg_wdata_i;
                    end
                    `EIA_OFF_IDATA_LO: begin
                        indirect_data_reg[7:0] <= reg_wdata_i;
                        data_written           <= 1'b1;
                    end
                    `EIA_OFF_IDATA_HI: begin
                        indirect_data_reg[15:8] <= reg_wdata_i;
                        data_written            <= 1'b1;
                    end
                    `EIA_OFF_IADDR: begin
                        indirect_address_reg    <= reg_wdata_i;
                        data_written            <= 1'b0;
                        indirect_pending_flag_o <= 1'b1;
                        state <= data_written ? ST_WR : ST_RD;
                    end
                    `EIA_OFF_RELAY: begin
                        relay_mode_bit <= reg_wdata_i[0];
                    end
                    `EIA_OFF_EXTERNAL_BATTERY_SELECT: begin
                        external_battery_select <= reg_wdata_i[0];
                    end
                    default: begin
                    end
                endcase
            end
            // Service only on the update tick; an address write in the same cycle wins.
            if (upd_tick && !(reg_wr_i && reg_addr_i == `EIA_OFF_IADDR)) begin
                case (state)
                    ST_WR: begin
                        state                   <= ST_IDLE;
                        indirect_pending_flag_o <= 1'b0;
                    end
                    ST_RD: begin
                        indirect_data_reg       <= ind_mem[ind_idx];
                        state                   <= ST_IDLE;
                        indirect_pending_flag_o <= 1'b0;
                    end
                    ST_IDLE: begin
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
            // Done flag: completion sets it and wins over a write-one clear.
            if (upd_tick && state != ST_IDLE && !(reg_wr_i && reg_addr_i == `EIA_OFF_IADDR)) begin
                indirect_done_irq_o <= 1'b1;
            end else if (reg_wr_i && reg_addr_i == `EIA_OFF_IRQ && reg_wdata_i[0]) begin
                indirect_done_irq_o <= 1'b0;
            end
        end
    end

    // Indirect memory has no reset, so its contents are undefined until written.
    always @(posedge ref_clk_i) begin
        if (upd_tick && state == ST_WR && !(reg_wr_i && reg_addr_i == `EIA_OFF_IADDR)) begin
            ind_mem[ind_idx] <= indirect_data_reg;
        end
    end

    // Read data mux; unmapped addresses read zero.
    always @* begin
        next_rdata = 8'h00;
        case (reg_addr_i)
            `EIA_OFF_PKCAL:    next_rdata = {4'h0, peak_monitor_cal_value};
            `EIA_OFF_ENH:      next_rdata = enhancement_enable;
            `EIA_OFF_IDATA_LO: next_rdata = indirect_data_reg[7:0];
            `EIA_OFF_IDATA_HI: next_rdata = indirect_data_reg[15:8];
            `EIA_OFF_IADDR:    next_rdata = indirect_address_reg;
            `EIA_OFF_STATUS:   next_rdata = {7'h00, indirect_pending_flag_o};
            `EIA_OFF_IRQ:      next_rdata = {7'h00, indirect_done_irq_o};
            `EIA_OFF_RELAY:    next_rdata = {7'h00, relay_mode_bit};
            `EIA_OFF_EXTERNAL_BATTERY_SELECT:   next_rdata = {7'h00, external_battery_select};
            default:           next_rdata = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe.
    always @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    // Boost holds from ring burst end until the boost bit is cleared; other writes leave it set.
    always @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ring_boost      <= 1'b0;
            current_limit_o <= 8'h00;
        end else begin
            if (!enhancement_enable[`EIA_ENH_PROGRAMMED_CURRENT_LIMIT]) begin
                ring_boost <= 1'b0;
            end else if (ring_burst_end_i) begin
                ring_boost <= 1'b1;
            end
            current_limit_o <= ring_boost ? `EIA_BOOST_MA : programmed_current_limit_i;
        end
    end

    // Battery switch request comes from the analog side, so it is synchronised first.
    always @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bat_sync_a       <= 1'b0;
            bat_sync_b       <= 1'b0;
            deb_count        <= 32'h0000_0000;
            battery_switch_o <= 1'b0;
        end else begin
            bat_sync_a <= battery_switch_req_i;
            bat_sync_b <= bat_sync_a;
            if (!(enhancement_enable[`EIA_ENH_BATTERY_SWITCH_DEBOUNCE_EN] && external_battery_select)) begin
                deb_count        <= 32'h0000_0000;
                battery_switch_o <= bat_sync_b;
            end else if (bat_sync_b == battery_switch_o) begin
                deb_count <= 32'h0000_0000;
            end else if (deb_count == DEB_CYC - 1) begin
                deb_count        <= 32'h0000_0000;
                battery_switch_o <= bat_sync_b;
            end else begin
                deb_count <= deb_count + 32'h0000_0001;
            end
        end
    end

    // Loop closure: voltage or current, the latter with optional hysteresis.
    // Thresholds themselves live in indirect words 28 and 43; no port here carries them to the analog comparators.
    always @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hyst_state    <= 1'b0;
            loop_closed_o <= 1'b0;
        end else begin
            if (loop_i_above_hi_i) begin
                hyst_state <= 1'b1;
            end else if (!loop_i_above_lo_i) begin
                hyst_state <= 1'b0;
            end
            if (enhancement_enable[`EIA_ENH_VOLTAGE_LOOP_CLOSURE_EN]) begin
                loop_closed_o <= loop_v_closed_i;
            end else if (enhancement_enable[`EIA_ENH_HYST]) begin
                loop_closed_o <= hyst_state;
            end else begin
                loop_closed_o <= loop_i_closed_i;
            end
        end
    end

    // Registered steering outputs toward the analog and tone blocks.
    always @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tone_gen_one_tick_o     <= 1'b0;
            fsk_regs_sel_o          <= 1'b0;
            fine_cadence_o          <= 1'b0;
            converter_multi_thr_o   <= 1'b0;
            impedance_ref_disable_o <= 1'b0;
            converter_squelch_o     <= 1'b0;
        end else begin
            // A rate change drops a stale tick of the newly chosen divider, so no runt period appears.
            tone_gen_one_tick_o     <= fsk_change ? 1'b0 : (fsk_active ? tg_fast_tick : tg_slow_tick);
            fsk_regs_sel_o          <= fsk_active;
            fine_cadence_o          <= fsk_active;
            converter_multi_thr_o   <= enhancement_enable[`EIA_ENH_CONVERTER_SPEEDUP_EN];
            impedance_ref_disable_o <= enhancement_enable[`EIA_ENH_IMPEDANCE_REF_DISABLE];
            converter_squelch_o     <= enhancement_enable[`EIA_ENH_CONVERTER_SQUELCH_EN];
        end
    end

    // Oscillator one frequency word: FSK set or normal set, read on every tone tick, pending transfer or not.
    always @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tone_gen_one_freq_o <= 16'h0000;
        end else if (tone_gen_one_tick_o) begin
            tone_gen_one_freq_o <= fsk_regs_sel_o ? ind_mem[`EIA_IND_FSK_FIRST] : ind_mem[0];
        end
    end
endmodule

`default_nettype wire

// file: inc/eia_defs.vh
`ifndef EIA_DEFS_VH
`define EIA_DEFS_VH

// Register byte offsets on the plain register port.
`define EIA_OFF_PKCAL      8'h6b
`define EIA_OFF_ENH        8'h6c
`define EIA_OFF_IDATA_LO   8'h1c
`define EIA_OFF_IDATA_HI   8'h1d
`define EIA_OFF_IADDR      8'h1e
`define EIA_OFF_STATUS     8'h1f
`define EIA_OFF_IRQ        8'h14
`define EIA_OFF_RELAY      8'h20
`define EIA_OFF_EXTERNAL_BATTERY_SELECT     8'h21

// Reset values.
`define EIA_RST_PKCAL      4'h8
`define EIA_RST_ENH        8'h00

// Enhancement enable field positions.
`define EIA_ENH_PROGRAMMED_CURRENT_LIMIT       7
`define EIA_ENH_FSK        6
`define EIA_ENH_CONVERTER_SPEEDUP_EN       5
`define EIA_ENH_IMPEDANCE_REF_DISABLE      4
`define EIA_ENH_BATTERY_SWITCH_DEBOUNCE_EN       3
`define EIA_ENH_VOLTAGE_LOOP_CLOSURE_EN       2
`define EIA_ENH_CONVERTER_SQUELCH_EN      1
`define EIA_ENH_HYST       0

// Indirect addresses used by the enhancements.
`define EIA_IND_FSK_FIRST  8'h63
`define EIA_IND_FSK_LAST   8'h68
`define EIA_IND_HYST_HI    8'h1c
`define EIA_IND_HYST_LO    8'h2b

// Timing figures.
`define EIA_CLK_HZ         50000000
`define EIA_UPD_HZ         16000
`define EIA_UPD_CYC        (`EIA_CLK_HZ / `EIA_UPD_HZ)
`define EIA_TG_SLOW_HZ     8000
`define EIA_TG_FAST_HZ     24000
`define EIA_TG_SLOW_CYC    (`EIA_CLK_HZ / `EIA_TG_SLOW_HZ)
`define EIA_TG_FAST_CYC    (`EIA_CLK_HZ / `EIA_TG_FAST_HZ)
`define EIA_DEB_MS         60
`define EIA_DEB_CYC        (`EIA_CLK_HZ / 1000 * `EIA_DEB_MS)
`define EIA_BOOST_MA       8'd41

`endif

// file: design/eia_tick_div.v
`timescale 1ns/1ps
`default_nettype none

module eia_tick_div #(
    parameter integer PERIOD = 3125
) (
    input  wire ref_clk_i,
    input  wire rst_b_i,
    input  wire restart_i,
    output reg  tick_o
);
    reg [31:0] count;

    // Free running divider; a restart realigns the phase when the rate changes.
    always @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count  <= 32'h0000_0000;
            tick_o <= 1'b0;
        end else if (restart_i) begin
            count  <= 32'h0000_0000;
            tick_o <= 1'b0;
        end else if (count == PERIOD - 1) begin
            count  <= 32'h0000_0000;
            tick_o <= 1'b1;
        end else begin
            count  <= count + 32'h0000_0001;
            tick_o <= 1'b0;
        end
    end
endmodule

`default_nettype wire

// file: verif/eia_enhancement_and_indirect_access_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "eia_defs.vh"

module eia_checker (
    input wire logic       ref_clk_i,
    input wire logic       rst_b_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [7:0] programmed_current_limit_i,
    input wire logic [7:0] current_limit_o,
    input wire logic       tone_gen_one_tick_o,
    input wire logic       fsk_regs_sel_o,
    input wire logic       fine_cadence_o,
    input wire logic       converter_multi_thr_o,
    input wire logic       impedance_ref_disable_o,
    input wire logic       converter_squelch_o,
    input wire logic       indirect_done_irq_o,
    input wire logic       indirect_pending_flag_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    logic [15:0] gap;
    logic [15:0] pend;

    // Tick spacing saturates so the slow rate never wraps; pending run length counts a whole wait.
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            gap  <= 16'hffff;
            pend <= 16'h0000;
        end else begin
            gap  <= tone_gen_one_tick_o ? 16'h0000 : ((gap == 16'hffff) ? gap : gap + 16'h0001);
            pend <= indirect_pending_flag_o ? pend + 16'h0001 : 16'h0000;
        end
    end

    pkcal_upper_zero_a: assert property (reg_rd_i && reg_addr_i == `EIA_OFF_PKCAL |=> reg_rdata_o[7:4] == 4'h0)
        else $error("calibration upper nibble not zero");
    boost_or_prog_a: assert property ($past(rst_b_i) && current_limit_o != `EIA_BOOST_MA
        |-> current_limit_o == $past(programmed_current_limit_i)) else $error("current limit wrong");
    tick_spacing_a: assert property (tone_gen_one_tick_o |-> gap >= 16'd2082)
        else $error("tone ticks too close");
    fsk_pair_a: assert property (fsk_regs_sel_o == fine_cadence_o)
        else $error("register select and cadence differ");
    pend_on_req_a: assert property (reg_wr_i && reg_addr_i == `EIA_OFF_IADDR |=> indirect_pending_flag_o)
        else $error("pending not set by request");
    pend_bound_a: assert property (pend <= 16'd3127)
        else $error("transfer not serviced by update");
    done_after_a: assert property ($fell(indirect_pending_flag_o) |=> indirect_done_irq_o)
        else $error("done flag not raised");
    // A completion in the clear's own cycle wins; it shows as pending falling one cycle later.
    done_clear_a: assert property (reg_wr_i && reg_addr_i == `EIA_OFF_IRQ && reg_wdata_i[0]
        |=> !indirect_done_irq_o || $fell(indirect_pending_flag_o)) else $error("done flag not cleared");
    enh_reset_a: assert property ($rose(rst_b_i) |-> !converter_multi_thr_o && !impedance_ref_disable_o
        && !converter_squelch_o && !fsk_regs_sel_o) else $error("enhancement on after reset");
    enh_levels_a: assert property (reg_wr_i && reg_addr_i == `EIA_OFF_ENH |-> ##2
        {converter_multi_thr_o, impedance_ref_disable_o, converter_squelch_o} ==
        {$past(reg_wdata_i[5], 2), $past(reg_wdata_i[4], 2), $past(reg_wdata_i[1], 2)})
        else $error("enhancement level wrong");
endmodule

bind eia_enhancement_and_indirect_access eia_checker eia_checker_i (.*);

`default_nettype wire

// file: verif/eia_enhancement_and_indirect_access_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "eia_defs.vh"

module eia_enhancement_and_indirect_access_tb_top;
    logic        ref_clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [7:0]  reg_wdata_i = 8'h00;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic        ring_burst_end_i = 1'b0;
    logic [7:0]  programmed_current_limit_i = 8'h14;
    logic        battery_switch_req_i = 1'b0;
    logic        loop_v_closed_i = 1'b0;
    logic        loop_i_above_hi_i = 1'b0;
    logic        loop_i_above_lo_i = 1'b0;
    logic        loop_i_closed_i = 1'b0;
    wire  [7:0]  reg_rdata_o;
    wire  [7:0]  current_limit_o;
    wire         tone_gen_one_tick_o;
    wire         fsk_regs_sel_o;
    wire         fine_cadence_o;
    wire         converter_multi_thr_o;
    wire         impedance_ref_disable_o;
    wire         battery_switch_o;
    wire         loop_closed_o;
    wire         converter_squelch_o;
    wire  [15:0] tone_gen_one_freq_o;
    wire         indirect_done_irq_o;
    wire         indirect_pending_flag_o;
    int          bad_count = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          n;

    // A short debounce keeps the run brief; expectations below use the same figure.
    eia_enhancement_and_indirect_access #(.DEB_CYC(20)) eia_enhancement_and_indirect_access_i (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .ring_burst_end_i(ring_burst_end_i),
        .programmed_current_limit_i(programmed_current_limit_i), .battery_switch_req_i(battery_switch_req_i),
        .loop_v_closed_i(loop_v_closed_i), .loop_i_above_hi_i(loop_i_above_hi_i),
        .loop_i_above_lo_i(loop_i_above_lo_i), .loop_i_closed_i(loop_i_closed_i),
        .current_limit_o(current_limit_o), .tone_gen_one_tick_o(tone_gen_one_tick_o),
        .fsk_regs_sel_o(fsk_regs_sel_o), .fine_cadence_o(fine_cadence_o),
        .converter_multi_thr_o(converter_multi_thr_o), .impedance_ref_disable_o(impedance_ref_disable_o),
        .battery_switch_o(battery_switch_o), .loop_closed_o(loop_closed_o),
        .converter_squelch_o(converter_squelch_o), .tone_gen_one_freq_o(tone_gen_one_freq_o),
        .indirect_done_irq_o(indirect_done_irq_o), .indirect_pending_flag_o(indirect_pending_flag_o)
    );

    // Clock, plus a ceiling that stops a hung run.
    always #10 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            bad_count = bad_count + 1;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge ref_clk_i);
        check({8'h00, reg_rdata_o}, {8'h00, exp});
    endtask

    task automatic wait_idle();
        @(negedge ref_clk_i);
        check({15'h0, indirect_pending_flag_o}, 16'h0001);
        check({15'h0, indirect_done_irq_o}, 16'h0000);
        n = 0;
        while (indirect_pending_flag_o === 1'b1 && n < 3300) begin
            @(negedge ref_clk_i);
            n++;
        end
        check({15'h0, n <= 3127}, 16'h0001);
        @(negedge ref_clk_i);
        check({15'h0, indirect_done_irq_o}, 16'h0001);
    endtask

    task automatic iw(input logic [7:0] a, input logic [15:0] d);
        wr(`EIA_OFF_IRQ, 8'h01);
        wr(`EIA_OFF_IDATA_LO, d[7:0]);
        wr(`EIA_OFF_IDATA_HI, d[15:8]);
        wr(`EIA_OFF_IADDR, a);
        wait_idle();
    endtask

    task automatic ir(input logic [7:0] a, input logic [15:0] exp);
        wr(`EIA_OFF_IRQ, 8'h01);
        wr(`EIA_OFF_IADDR, a);
        wait_idle();
        rdc(`EIA_OFF_IDATA_LO, exp[7:0]);
        rdc(`EIA_OFF_IDATA_HI, exp[15:8]);
    endtask

    task automatic lc(input logic [3:0] ins, input logic exp);
        @(posedge ref_clk_i);
        {loop_v_closed_i, loop_i_closed_i, loop_i_above_hi_i, loop_i_above_lo_i} <= ins;
        repeat (4) @(negedge ref_clk_i);
        check({15'h0, loop_closed_o}, {15'h0, exp});
    endtask

    task automatic bsw(input logic req, input int waitc, input logic exp);
        @(posedge ref_clk_i);
        battery_switch_req_i <= req;
        repeat (waitc) @(negedge ref_clk_i);
        check({15'h0, battery_switch_o}, {15'h0, exp});
    endtask

    // Second tick gap is a full period measured in cycles.
    task automatic tick_gap();
        repeat (2) begin
            n = 0;
            do begin
                @(negedge ref_clk_i);
                n++;
            end while (tone_gen_one_tick_o !== 1'b1 && n < 7000);
        end
    endtask

    task automatic t_regs();
        rdc(`EIA_OFF_PKCAL, 8'h08);
        rdc(`EIA_OFF_ENH, 8'h00);
        rdc(8'h7f, 8'h00);
        wr(`EIA_OFF_PKCAL, 8'hff);
        rdc(`EIA_OFF_PKCAL, 8'h0f);
        wr(`EIA_OFF_ENH, 8'ha5);
        rdc(`EIA_OFF_ENH, 8'ha5);
        for (int i = 0; i < 8; i++) begin
            wr(`EIA_OFF_ENH, 8'h01 << i);
            repeat (3) @(negedge ref_clk_i);
            check({converter_multi_thr_o, impedance_ref_disable_o, converter_squelch_o}, {i == 5, i == 4, i == 1});
        end
    endtask

    task automatic t_loop_boost();
        wr(`EIA_OFF_ENH, 8'h04);
        lc(4'b1000, 1'b1);
        lc(4'b0100, 1'b0);
        wr(`EIA_OFF_ENH, 8'h00);
        lc(4'b0100, 1'b1);
        wr(`EIA_OFF_ENH, 8'h01);
        lc(4'b0011, 1'b1);
        lc(4'b0001, 1'b1);
        lc(4'b0000, 1'b0);
        for (int b = 0; b < 2; b++) begin
            wr(`EIA_OFF_ENH, b ? 8'h80 : 8'h00);
            @(posedge ref_clk_i);
            ring_burst_end_i <= 1'b1;
            @(posedge ref_clk_i);
            ring_burst_end_i <= 1'b0;
            repeat (3) @(negedge ref_clk_i);
            check({8'h00, current_limit_o}, b ? 16'h0029 : 16'h0014);
        end
        wr(`EIA_OFF_ENH, 8'h00);
        repeat (3) @(negedge ref_clk_i);
        check({8'h00, current_limit_o}, 16'h0014);
        @(posedge ref_clk_i);
        programmed_current_limit_i <= 8'h1f;
        repeat (3) @(negedge ref_clk_i);
        check({8'h00, current_limit_o}, 16'h001f);
    endtask

    task automatic t_debounce();
        wr(`EIA_OFF_EXTERNAL_BATTERY_SELECT, 8'h01);
        bsw(1'b1, 6, 1'b1);
        bsw(1'b0, 6, 1'b0);
        wr(`EIA_OFF_ENH, 8'h08);
        bsw(1'b1, 10, 1'b0);
        repeat (30) @(negedge ref_clk_i);
        check({15'h0, battery_switch_o}, 16'h0001);
    endtask

    task automatic t_indirect();
        iw(8'h05, 16'h1234);
        iw(8'h06, 16'hbeef);
        ir(8'h05, 16'h1234);
        ir(8'h06, 16'hbeef);
        rdc(`EIA_OFF_STATUS, 8'h00);
        rdc(`EIA_OFF_IRQ, 8'h01);
        wr(`EIA_OFF_IRQ, 8'h01);
        rdc(`EIA_OFF_IRQ, 8'h00);
    endtask

    task automatic t_fsk();
        iw(8'h00, 16'h1111);
        iw(`EIA_IND_FSK_FIRST, 16'h2222);
        wr(`EIA_OFF_RELAY, 8'h01);
        wr(`EIA_OFF_ENH, 8'h40);
        repeat (3) @(negedge ref_clk_i);
        check({fsk_regs_sel_o, fine_cadence_o}, 16'h0003);
        tick_gap();
        check(16'(n), 16'(`EIA_TG_FAST_CYC));
        repeat (2) @(negedge ref_clk_i);
        check(tone_gen_one_freq_o, 16'h2222);
        wr(`EIA_OFF_RELAY, 8'h00);
        repeat (3) @(negedge ref_clk_i);
        check({fsk_regs_sel_o, fine_cadence_o}, 16'h0000);
        tick_gap();
        check(16'(n), 16'(`EIA_TG_SLOW_CYC));
        repeat (2) @(negedge ref_clk_i);
        check(tone_gen_one_freq_o, 16'h1111);
    endtask

    // Reset for three cycles, then each scenario in turn.
    initial begin
        repeat (3) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        t_regs();
        t_loop_boost();
        t_debounce();
        t_indirect();
        t_fsk();
        end_sim();
    end
endmodule

`default_nettype wire
